// >>> hw/dafs_core.sv
// Auxiliary frequency shaping block with APB register file.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
module dafs_core
	import dafs_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int HOUR_TENTHS = TENTHS_PER_H
)(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Drive inputs
	input  wire logic [15:0] TARGET_FREQ,
	input  wire logic [15:0] LOAD_LEVEL,
	input  wire logic [1:0]  RAMP_SEL_TERM,
	input  wire logic        JOG_TERM,
	// Drive outputs
	output logic      [15:0] OUT_FREQ,
	output logic             OUT_REVERSE,
	output logic             OUT_ENABLE,
	output logic      [15:0] RAMP_TIME,
	output logic             START_MODE,
	output logic             STOP_MODE,
	output logic             PON_REACHED,
	output logic             RUN_REACHED,
	output logic             IRQ
);

	// =========================================================
	// State
	typedef struct packed {
		dafs_cfg_t   cfg;
		dafs_state_t st;
		logic [1:0]  rs_m;
		logic [1:0]  rs;
		logic        jog_m;
		logic        jog;
		logic [31:0] tick_cnt;
		logic [15:0] pon_tenths;
		logic [15:0] run_tenths;
		logic [15:0] pon_total;
		logic [15:0] run_total;
		logic [15:0] dead_cnt;
		logic [15:0] freq;
		logic        rev;
		logic        jogging;
		logic        run_stop;
		logic [NUM_EV-1:0] irq_status;
		logic [NUM_EV-1:0] irq_mask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [15:0] ramp_time;
		logic        pon_hit;
		logic        run_hit;
		logic        irq;
		logic        out_en;
		logic        start_md;
		logic        stop_md;
	} dafs_core_state_t;

	dafs_core_state_t s;
	dafs_core_state_t next_s;

	logic [15:0] band_lo [2];
	logic [15:0] band_hi [2];
	logic [1:0]  band_on;

	// =========================================================
	// Jump band edges
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_band
			logic [15:0] jf;
			assign jf = (g == 0) ? s.cfg.jump_frequency_one
			                     : s.cfg.jump_frequency_two;
			assign band_lo[g] = (jf > s.cfg.jump_amplitude)
				? 16'(jf - s.cfg.jump_amplitude) : 16'h0000;
			assign band_hi[g] = 16'(jf + s.cfg.jump_amplitude);
			assign band_on[g] = (jf != 16'h0000);
		end
	endgenerate

	// =========================================================
	// Next-state logic
	always_comb
	begin
		logic [15:0] req;
		logic [15:0] drop;
		logic        want_rev;
		logic        tick;
		logic        ev_pon;
		logic        ev_runt;
		logic        ev_revr;
		logic [31:0] rd;
		logic        hit;
		logic        wr;
		logic [7:0]  ai;
		logic [7:0]  di;
		logic        low_stop;
		req      = 16'h0000;
		drop     = 16'h0000;
		want_rev = 1'b0;
		ev_pon   = 1'b0;
		ev_runt  = 1'b0;
		ev_revr  = 1'b0;
		rd       = 32'h0000_0000;
		hit      = 1'b1;
		ai       = 8'h00;
		di       = 8'h00;
		tick     = 1'b0;
		wr       = 1'b0;
		low_stop = 1'b0;
		next_s   = s;

		next_s.rs_m  = RAMP_SEL_TERM;
		next_s.rs    = s.rs_m;
		next_s.jog_m = JOG_TERM;
		next_s.jog   = s.jog_m;

		// Tenth-second tick and hour counters.
		tick = (s.tick_cnt == 32'(TICK_CYC - 1));
		next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h1;
		if (tick)
		begin
			if (s.pon_tenths == 16'(HOUR_TENTHS - 1))
			begin
				next_s.pon_tenths = 16'h0000;
				if (s.pon_total != HOURS_MAX)
					next_s.pon_total = s.pon_total + 16'h1;
			end
			else
				next_s.pon_tenths = s.pon_tenths + 16'h1;
			if (s.st == ST_RUN || s.st == ST_DEAD)
			begin
				if (s.run_tenths == 16'(HOUR_TENTHS - 1))
				begin
					next_s.run_tenths = 16'h0000;
					if (s.run_total != HOURS_MAX)
						next_s.run_total = s.run_total + 16'h1;
				end
				else
					next_s.run_tenths = s.run_tenths + 16'h1;
			end
		end

		// Threshold outputs.
		next_s.pon_hit = (s.pon_total >= s.cfg.power_on_hours_threshold);
		next_s.run_hit = (s.run_total >= s.cfg.run_hours_threshold);
		ev_pon  = next_s.pon_hit && !s.pon_hit;
		ev_runt = next_s.run_hit && !s.run_hit;

		// Jog entry and exit.
		if (s.jog && (s.st == ST_IDLE
		    || (s.cfg.terminal_jog_priority && s.st == ST_RUN)))
			next_s.jogging = 1'b1;
		else if (!s.jog)
			next_s.jogging = 1'b0;

		// Requested frequency.
		want_rev = s.cfg.control[CTL_REV] && !s.jogging;
		if (want_rev && s.cfg.reverse_inhibit)
		begin
			want_rev = 1'b0;
			ev_revr  = 1'b1;
		end
		if (s.jogging)
			req = s.cfg.jog_frequency;
		else if (s.run_stop)
			req = 16'h0000;
		else if (!s.cfg.control[CTL_RUN])
			req = 16'h0000;
		else if (TARGET_FREQ < s.cfg.low_limit)
		begin
			case (s.cfg.below_limit_action)
				BELOW_RUN_LOW: req = s.cfg.low_limit;
				BELOW_STOP:    req = 16'h0000;
				BELOW_ZERO:    req = 16'h0000;
				default:       req = s.cfg.low_limit;
			endcase
		end
		else
			req = TARGET_FREQ;

		low_stop = (s.cfg.below_limit_action == BELOW_STOP)
			&& (TARGET_FREQ < s.cfg.low_limit) && !s.jogging;

		// Droop reduces target with load.
		drop = (s.cfg.droop_amount > DROOP_MAX) ? DROOP_MAX
		                                         : s.cfg.droop_amount;
		drop = 16'((32'(drop) * 32'(LOAD_LEVEL)) >> 16);
		req  = (req > drop) ? 16'(req - drop) : 16'h0000;

		// Clamp requested frequency out of jump bands.
		for (int i = 0; i < 2; i++)
		begin
			if (band_on[i] && req > band_lo[i] && req < band_hi[i])
				req = (16'(req - band_lo[i]) < 16'(band_hi[i] - req))
					? band_lo[i] : band_hi[i];
		end

		// Ramp time selection.
		if (s.jogging)
			next_s.ramp_time = (req >= s.freq) ? s.cfg.jog_accel_time
			                                   : s.cfg.jog_decel_time;
		else if (s.cfg.control[CTL_DI_SEL] || s.cfg.control[CTL_MOTOR2])
			next_s.ramp_time = (req >= s.freq) ? s.cfg.accel_time[s.rs]
			                                   : s.cfg.decel_time[s.rs];
		else if (req >= s.freq)
			next_s.ramp_time = (s.freq < s.cfg.accel_switch_point)
				? s.cfg.accel_time[0] : s.cfg.accel_time[1];
		else
			next_s.ramp_time = (s.freq > s.cfg.decel_switch_point)
				? s.cfg.decel_time[0] : s.cfg.decel_time[1];

		// Run state machine; frequency steps once per tick.
		case (s.st)
			ST_IDLE:
			begin
				next_s.freq = 16'h0000;
				if ((s.cfg.control[CTL_RUN] || s.jogging) && !s.run_stop
				    && !low_stop)
				begin
					next_s.st  = ST_RUN;
					next_s.rev = want_rev;
				end
			end
			ST_RUN:
			begin
				if (want_rev != s.rev && s.freq != 16'h0000)
					req = 16'h0000;
				if (want_rev != s.rev && s.freq == 16'h0000)
				begin
					next_s.st       = ST_DEAD;
					next_s.dead_cnt = s.cfg.direction_dead_zone;
				end
				else if (tick)
				begin
					if (s.freq < req)
						next_s.freq = s.freq + 16'h1;
					else if (s.freq > req)
						next_s.freq = s.freq - 16'h1;
					if (s.cfg.jump_during_ramp)
						for (int i = 0; i < 2; i++)
							if (band_on[i] && next_s.freq > band_lo[i]
							    && next_s.freq < band_hi[i])
								next_s.freq = (s.freq < req)
									? band_hi[i] : band_lo[i];
				end
				if (!s.cfg.control[CTL_RUN] && !s.jogging)
				begin
					if (s.jog || s.cfg.stop_mode_select != STOP_RAMP)
						next_s.st = (s.jogging) ? ST_RUN : ST_STOP;
					else
						next_s.st = ST_STOP;
				end
				if (s.run_stop || low_stop)
					next_s.st = ST_STOP;
				// A free stop cuts the output in the same step.
				if (next_s.st == ST_STOP && !s.jogging
				    && s.cfg.stop_mode_select != STOP_RAMP)
					next_s.freq = 16'h0000;
			end
			ST_DEAD:
			begin
				next_s.freq = 16'h0000;
				if (s.dead_cnt == 16'h0000)
				begin
					next_s.st  = ST_RUN;
					next_s.rev = want_rev;
				end
				else if (tick)
					next_s.dead_cnt = s.dead_cnt - 16'h1;
			end
			ST_STOP:
			begin
				// Jog always ramps down; otherwise free stop cuts output.
				if (s.jogging || s.cfg.stop_mode_select == STOP_RAMP)
				begin
					if (tick && s.freq != 16'h0000)
						next_s.freq = s.freq - 16'h1;
				end
				else
					next_s.freq = 16'h0000;
				if (next_s.freq == 16'h0000)
					next_s.st = ST_IDLE;
			end
			default: next_s.st = ST_IDLE;
		endcase

		// APB register access, zero wait states.
		wr = PSEL && PENABLE && PWRITE;
		next_s.pready  = PSEL && !PENABLE;
		next_s.pslverr = 1'b0;
		ai = PADDR - OFS_ACCEL_BASE;
		di = PADDR - OFS_DECEL_BASE;
		case (PADDR)
			OFS_JOG_FREQ:     rd = 32'(s.cfg.jog_frequency);
			OFS_JOG_ACCEL:    rd = 32'(s.cfg.jog_accel_time);
			OFS_JOG_DECEL:    rd = 32'(s.cfg.jog_decel_time);
			OFS_JUMP_ONE:     rd = 32'(s.cfg.jump_frequency_one);
			OFS_JUMP_TWO:     rd = 32'(s.cfg.jump_frequency_two);
			OFS_JUMP_AMP:     rd = 32'(s.cfg.jump_amplitude);
			OFS_JUMP_RAMP:    rd = 32'(s.cfg.jump_during_ramp);
			OFS_ACCEL_SW:     rd = 32'(s.cfg.accel_switch_point);
			OFS_DECEL_SW:     rd = 32'(s.cfg.decel_switch_point);
			OFS_REV_INHIBIT:  rd = 32'(s.cfg.reverse_inhibit);
			OFS_DEAD_ZONE:    rd = 32'(s.cfg.direction_dead_zone);
			OFS_BELOW_ACTION: rd = 32'(s.cfg.below_limit_action);
			OFS_DROOP:        rd = 32'(s.cfg.droop_amount);
			OFS_JOG_PRIO:     rd = 32'(s.cfg.terminal_jog_priority);
			OFS_PON_THRESH:   rd = 32'(s.cfg.power_on_hours_threshold);
			OFS_RUN_THRESH:   rd = 32'(s.cfg.run_hours_threshold);
			OFS_RUN_ACTION:   rd = 32'(s.cfg.run_time_reached_action);
			OFS_START_MODE:   rd = 32'(s.cfg.start_mode_select);
			OFS_STOP_MODE:    rd = 32'(s.cfg.stop_mode_select);
			OFS_LOW_LIMIT:    rd = 32'(s.cfg.low_limit);
			OFS_CONTROL:      rd = 32'(s.cfg.control);
			OFS_STATUS:       rd = {24'h000000, s.st, s.run_stop,
			                        s.jogging, s.rev, s.run_hit};
			OFS_IRQ_STATUS:   rd = 32'(s.irq_status);
			OFS_IRQ_MASK:     rd = 32'(s.irq_mask);
			OFS_PON_TOTAL:    rd = 32'(s.pon_total);
			OFS_RUN_TOTAL:    rd = 32'(s.run_total);
			OFS_OUT_FREQ:     rd = 32'(s.freq);
			default:
			begin
				if (PADDR >= OFS_ACCEL_BASE && PADDR < OFS_DECEL_BASE)
					rd = 32'(s.cfg.accel_time[ai[3:2]]);
				else if (PADDR >= OFS_DECEL_BASE && PADDR < OFS_JUMP_ONE)
					rd = 32'(s.cfg.decel_time[di[3:2]]);
				else
					hit = 1'b0;
			end
		endcase
		if (PSEL && !PENABLE)
		begin
			next_s.prdata  = rd;
			next_s.pslverr = !hit;
		end

		if (wr && hit)
		begin
			case (PADDR)
				OFS_JOG_FREQ:     next_s.cfg.jog_frequency = PWDATA[15:0];
				OFS_JOG_ACCEL:    next_s.cfg.jog_accel_time =
				                  (PWDATA[15:0] > TIME_MAX) ? TIME_MAX : PWDATA[15:0];
				OFS_JOG_DECEL:    next_s.cfg.jog_decel_time =
				                  (PWDATA[15:0] > TIME_MAX) ? TIME_MAX : PWDATA[15:0];
				OFS_JUMP_ONE:     next_s.cfg.jump_frequency_one = PWDATA[15:0];
				OFS_JUMP_TWO:     next_s.cfg.jump_frequency_two = PWDATA[15:0];
				OFS_JUMP_AMP:     next_s.cfg.jump_amplitude = PWDATA[15:0];
				OFS_JUMP_RAMP:    next_s.cfg.jump_during_ramp = PWDATA[0];
				OFS_ACCEL_SW:     next_s.cfg.accel_switch_point = PWDATA[15:0];
				OFS_DECEL_SW:     next_s.cfg.decel_switch_point = PWDATA[15:0];
				OFS_REV_INHIBIT:  next_s.cfg.reverse_inhibit = PWDATA[0];
				OFS_DEAD_ZONE:    next_s.cfg.direction_dead_zone =
				                  (PWDATA[15:0] > DEAD_MAX) ? DEAD_MAX : PWDATA[15:0];
				OFS_BELOW_ACTION: next_s.cfg.below_limit_action = PWDATA[1:0];
				OFS_DROOP:        next_s.cfg.droop_amount = PWDATA[15:0];
				OFS_JOG_PRIO:     next_s.cfg.terminal_jog_priority = PWDATA[0];
				OFS_PON_THRESH:   next_s.cfg.power_on_hours_threshold =
				                  (PWDATA[15:0] > HOURS_MAX) ? HOURS_MAX : PWDATA[15:0];
				OFS_RUN_THRESH:   next_s.cfg.run_hours_threshold =
				                  (PWDATA[15:0] > HOURS_MAX) ? HOURS_MAX : PWDATA[15:0];
				OFS_RUN_ACTION:   next_s.cfg.run_time_reached_action = PWDATA[0];
				OFS_START_MODE:   next_s.cfg.start_mode_select = PWDATA[0];
				OFS_STOP_MODE:    next_s.cfg.stop_mode_select = PWDATA[0];
				OFS_LOW_LIMIT:    next_s.cfg.low_limit = PWDATA[15:0];
				OFS_CONTROL:
				begin
					next_s.cfg.control = PWDATA[3:0];
					if (!PWDATA[CTL_RUN])
						next_s.run_stop = 1'b0;
				end
				OFS_IRQ_STATUS:   next_s.irq_status = s.irq_status & ~PWDATA[NUM_EV-1:0];
				OFS_IRQ_MASK:     next_s.irq_mask = PWDATA[NUM_EV-1:0];
				default:
				begin
					if (PADDR >= OFS_ACCEL_BASE && PADDR < OFS_DECEL_BASE)
						next_s.cfg.accel_time[ai[3:2]] =
							(PWDATA[15:0] > TIME_MAX) ? TIME_MAX : PWDATA[15:0];
					else if (PADDR >= OFS_DECEL_BASE && PADDR < OFS_JUMP_ONE)
						next_s.cfg.decel_time[di[3:2]] =
							(PWDATA[15:0] > TIME_MAX) ? TIME_MAX : PWDATA[15:0];
				end
			endcase
		end

		// Run-time stop is set after a control clear so set wins.
		if (ev_runt && s.cfg.run_time_reached_action)
			next_s.run_stop = 1'b1;

		// Events set after any clear so set wins.
		next_s.irq_status = next_s.irq_status | {ev_revr, ev_runt, ev_pon};
		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
		next_s.out_en   = (next_s.st != ST_IDLE);
		next_s.start_md = next_s.jogging
			? START_DIRECT : next_s.cfg.start_mode_select;
		next_s.stop_md  = next_s.jogging
			? STOP_RAMP : next_s.cfg.stop_mode_select;
	end

	// =========================================================
	// Registers
	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.cfg.jog_frequency <= RST_JOG_FREQ;
			s.pon_hit <= 1'b1;
			s.run_hit <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign PRDATA      = s.prdata;
	assign PREADY      = s.pready;
	assign PSLVERR     = s.pslverr;
	assign OUT_FREQ    = s.freq;
	assign OUT_REVERSE = s.rev;
	assign OUT_ENABLE  = s.out_en;
	assign RAMP_TIME   = s.ramp_time;
	assign START_MODE  = s.start_md;
	assign STOP_MODE   = s.stop_md;
	assign PON_REACHED = s.pon_hit;
	assign RUN_REACHED = s.run_hit;
	assign IRQ         = s.irq;

endmodule // dafs_core

// >>> hw/dafs_pkg.sv
// Package with register map, field layouts and timing constants.
package dafs_pkg;

	// =========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_JOG_FREQ      = 8'h00;
	localparam logic [7:0] OFS_JOG_ACCEL     = 8'h04;
	localparam logic [7:0] OFS_JOG_DECEL     = 8'h08;
	localparam logic [7:0] OFS_ACCEL_BASE    = 8'h0C;
	localparam logic [7:0] OFS_DECEL_BASE    = 8'h1C;
	localparam logic [7:0] OFS_JUMP_ONE      = 8'h2C;
	localparam logic [7:0] OFS_JUMP_TWO      = 8'h30;
	localparam logic [7:0] OFS_JUMP_AMP      = 8'h34;
	localparam logic [7:0] OFS_JUMP_RAMP     = 8'h38;
	localparam logic [7:0] OFS_ACCEL_SW      = 8'h3C;
	localparam logic [7:0] OFS_DECEL_SW      = 8'h40;
	localparam logic [7:0] OFS_REV_INHIBIT   = 8'h44;
	localparam logic [7:0] OFS_DEAD_ZONE     = 8'h48;
	localparam logic [7:0] OFS_BELOW_ACTION  = 8'h4C;
	localparam logic [7:0] OFS_DROOP         = 8'h50;
	localparam logic [7:0] OFS_JOG_PRIO      = 8'h54;
	localparam logic [7:0] OFS_PON_THRESH    = 8'h58;
	localparam logic [7:0] OFS_RUN_THRESH    = 8'h5C;
	localparam logic [7:0] OFS_RUN_ACTION    = 8'h60;
	localparam logic [7:0] OFS_START_MODE    = 8'h64;
	localparam logic [7:0] OFS_STOP_MODE     = 8'h68;
	localparam logic [7:0] OFS_LOW_LIMIT     = 8'h6C;
	localparam logic [7:0] OFS_CONTROL       = 8'h70;
	localparam logic [7:0] OFS_STATUS        = 8'h74;
	localparam logic [7:0] OFS_IRQ_STATUS    = 8'h78;
	localparam logic [7:0] OFS_IRQ_MASK      = 8'h7C;
	localparam logic [7:0] OFS_PON_TOTAL     = 8'h80;
	localparam logic [7:0] OFS_RUN_TOTAL     = 8'h84;
	localparam logic [7:0] OFS_OUT_FREQ      = 8'h88;

	// =========================================================
	// Reset values, limits and encodings
	localparam logic [15:0] RST_JOG_FREQ = 16'h0258;
	localparam logic [15:0] RST_ZERO     = 16'h0000;
	localparam logic [15:0] DROOP_MAX    = 16'h03E8;
	localparam logic [15:0] TIME_MAX     = 16'hFDE8;
	localparam logic [15:0] DEAD_MAX     = 16'h7530;
	localparam logic [15:0] HOURS_MAX    = 16'hFDE8;
	localparam logic [1:0]  BELOW_RUN_LOW  = 2'h0;
	localparam logic [1:0]  BELOW_STOP     = 2'h1;
	localparam logic [1:0]  BELOW_ZERO     = 2'h2;
	localparam logic        START_DIRECT   = 1'b0;
	localparam logic        STOP_RAMP      = 1'b0;

	// Control register bits.
	localparam int CTL_RUN    = 0;
	localparam int CTL_REV    = 1;
	localparam int CTL_MOTOR2 = 2;
	localparam int CTL_DI_SEL = 3;

	// Interrupt and status bits.
	localparam int EV_PON  = 0;
	localparam int EV_RUNT = 1;
	localparam int EV_REVR = 2;
	localparam int NUM_EV  = 3;

	// =========================================================
	// Timing: one tenth of a second tick and one hour in ticks
	localparam int  CLK_HZ        = 40000000;
	localparam int  TENTH_S       = 10;
	localparam int  TICK_CYCLES   = CLK_HZ / TENTH_S;
	localparam int  TENTHS_PER_H  = 36000;

	// =========================================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_RUN   = 4'b0010,
		ST_DEAD  = 4'b0100,
		ST_STOP  = 4'b1000
	} dafs_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dafs_apb_req_t;

	typedef struct packed {
		logic [15:0] jog_frequency;
		logic [15:0] jog_accel_time;
		logic [15:0] jog_decel_time;
		logic [3:0][15:0] accel_time;
		logic [3:0][15:0] decel_time;
		logic [15:0] jump_frequency_one;
		logic [15:0] jump_frequency_two;
		logic [15:0] jump_amplitude;
		logic        jump_during_ramp;
		logic [15:0] accel_switch_point;
		logic [15:0] decel_switch_point;
		logic        reverse_inhibit;
		logic [15:0] direction_dead_zone;
		logic [1:0]  below_limit_action;
		logic [15:0] droop_amount;
		logic        terminal_jog_priority;
		logic [15:0] power_on_hours_threshold;
		logic [15:0] run_hours_threshold;
		logic        run_time_reached_action;
		logic        start_mode_select;
		logic        stop_mode_select;
		logic [15:0] low_limit;
		logic [3:0]  control;
	} dafs_cfg_t;

endpackage

// >>> testbench/dafs_core_assertions.sv
// Port-level checker for the frequency shaping block.
`timescale 1ns/100ps
module dafs_core_checker
	import dafs_pkg::*;
(
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        SYS_RST,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic        PREADY,
	// Drive outputs
	input wire logic [15:0] OUT_FREQ,
	input wire logic        OUT_REVERSE,
	input wire logic        OUT_ENABLE,
	input wire logic        PON_REACHED,
	input wire logic        RUN_REACHED,
	input wire logic        IRQ
);
	// =========================================================
	// Helpers
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	logic wr_acc;
	assign wr_acc = PSEL & PENABLE & PWRITE;

	// =========================================================
	// Assertions
	a_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("PREADY missing after setup.");
	a_ready_phase: assert property (PREADY |-> PSEL && PENABLE)
		else $error("PREADY outside access phase.");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("PREADY longer than one cycle.");
	a_reset_state: assert property ($fell(SYS_RST) |->
		OUT_FREQ == 16'h0000 && !OUT_ENABLE && !IRQ
		&& PON_REACHED && RUN_REACHED)
		else $error("Wrong output state after reset.");
	a_idle_zero: assert property (!OUT_ENABLE |-> OUT_FREQ == 16'h0000)
		else $error("Frequency nonzero while idle.");
	a_step_hold: assert property (
		OUT_FREQ != $past(OUT_FREQ) |=> $stable(OUT_FREQ))
		else $error("Frequency moved on two cycles running.");
	a_dead_zero: assert property (
		$changed(OUT_REVERSE) |-> OUT_FREQ == 16'h0000)
		else $error("Direction changed above 0 Hz.");
	a_pon_fall: assert property ($fell(PON_REACHED) |->
		$past(wr_acc, 1) || $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("Power-on output dropped without a write.");
	a_run_fall: assert property ($fell(RUN_REACHED) |->
		$past(wr_acc, 1) || $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("Running output dropped without a write.");

	// =========================================================
	// Covers
	c_reverse: cover property ($changed(OUT_REVERSE));
	c_pon: cover property ($rose(PON_REACHED));
	c_irq: cover property ($rose(IRQ));
endmodule // dafs_core_checker

bind dafs_core dafs_core_checker i_chk (.MCLK, .SYS_RST, .PSEL, .PENABLE,
	.PWRITE, .PREADY, .OUT_FREQ, .OUT_REVERSE, .OUT_ENABLE, .PON_REACHED,
	.RUN_REACHED, .IRQ);

// >>> testbench/dafs_motor_model.sv
// Motor stage model that loads the drive while it turns.
`timescale 1ns/100ps
module dafs_motor_model
	import dafs_pkg::*;
(
	// Drive side
	input  wire logic [15:0] freq,
	input  wire logic        enable,
	// Commanded load
	input  wire logic [15:0] load_cmd,
	// Load feedback
	output logic      [15:0] load
);
	// A stopped shaft carries no load.
	assign load = (enable === 1'b1 && freq != 16'h0000) ? load_cmd : 16'h0000;
endmodule // dafs_motor_model

// >>> testbench/drive_aux_frequency_shaping_bench.sv
// Self-checking bench for the frequency shaping block.
`timescale 1ns/100ps
module drive_aux_frequency_shaping_bench
	import dafs_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [15:0] tgt = 16'h0000;
	logic [15:0] ldc = 16'h0000;
	logic [1:0]  rsel = 2'h0;
	logic        jog = 1'b0;
	logic [31:0] prdata, r;
	logic [15:0] load, ofreq, rtime;
	logic [15:0] acc [4];
	logic        pready, pslverr, e, orev, oen, smode, tmode, pon, runr, irq;
	int          failures = 0;
	int          comparisons = 0;
	int          seed = 32'hC9E4;
	int          n, t, m_lo, m_act, m_jmp, m_amp, m_drp, inband;
	int          acts [3] = '{0, 2, 1};

	dafs_core #(.TICK_CYC(4), .HOUR_TENTHS(3)) i_dut (.MCLK(clk),
		.SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TARGET_FREQ(tgt), .LOAD_LEVEL(load),
		.RAMP_SEL_TERM(rsel), .JOG_TERM(jog), .OUT_FREQ(ofreq),
		.OUT_REVERSE(orev), .OUT_ENABLE(oen), .RAMP_TIME(rtime),
		.START_MODE(smode), .STOP_MODE(tmode), .PON_REACHED(pon),
		.RUN_REACHED(runr), .IRQ(irq));
	dafs_motor_model i_motor (.freq(ofreq), .enable(oen), .load_cmd(ldc),
		.load(load));

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	// Counts cycles spent inside the 95..105 jump band.
	always @(posedge clk)
		if (ofreq > 16'h005F && ofreq < 16'h0069)
			inband++;

	// =========================================================
	// Tasks and reference model
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		comparisons++;
		if (got !== x)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000);
		chk(r, x);
	endtask

	task automatic wf(input int x);
		for (n = 0; n < 3000 && ofreq !== x[15:0]; n++)
			@(posedge clk);
		chk({16'h0000, ofreq}, x);
	endtask

	function automatic int fx(input int q);
		int f;
		f = (q < m_lo) ? ((m_act == 0) ? m_lo : 0) : q;
		f = (f > m_drp) ? f - m_drp : 0;
		if (m_jmp != 0 && f >= m_jmp - m_amp && f <= m_jmp + m_amp)
			f = (f >= m_jmp) ? m_jmp + m_amp : m_jmp - m_amp;
		return f;
	endfunction

	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		report_and_stop;
	end

	// =========================================================
	// Scenarios
	initial
	begin
		{m_lo, m_act, m_jmp, m_amp, m_drp, inband} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({30'h0, pon, runr}, 32'h3);
		rdc(OFS_JOG_FREQ, {16'h0000, RST_JOG_FREQ});
		rdc(OFS_REV_INHIBIT, 32'h0);
		rdc(OFS_BELOW_ACTION, 32'h0);
		rdc(OFS_JOG_PRIO, 32'h0);
		rdc(OFS_RUN_ACTION, 32'h0);
		apb(1'b0, 8'hFC, 32'h00000000);
		chk({r[30:0], e}, 32'h1);
		for (int g = 0; g < 4; g++)
		begin
			acc[g] = 16'($random(seed)) & 16'h7FFF;
			wr(OFS_ACCEL_BASE + 8'(4 * g), acc[g]);
			rdc(OFS_ACCEL_BASE + 8'(4 * g), {16'h0, acc[g]});
		end
		t = 30 + ($random(seed) & 15);
		tgt <= t[15:0];
		wr(OFS_CONTROL, 16'h0009);
		for (int g = 0; g < 4; g++)
		begin
			rsel <= g[1:0];
			repeat (6) @(posedge clk);
			chk({16'h0, rtime}, {16'h0, acc[g]});
		end
		wf(fx(t));
		wr(OFS_ACCEL_SW, 16'h003C);
		wr(OFS_CONTROL, 16'h0001);
		tgt <= 16'h0050;
		wf(50);
		chk({16'h0, rtime}, {16'h0, acc[0]});
		wf(70);
		chk({16'h0, rtime}, {16'h0, acc[1]});
		m_jmp = 100;
		m_amp = 5;
		wr(OFS_JUMP_TWO, 16'h0064);
		wr(OFS_JUMP_AMP, 16'h0005);
		wr(OFS_JUMP_RAMP, 16'h0001);
		tgt <= 16'h0065;
		wf(fx(101));
		m_drp = 5;
		wr(OFS_DROOP, 16'h000A);
		ldc <= 16'h8000;
		wf(fx(101));
		m_drp = 0;
		ldc <= 16'h0000;
		wr(OFS_DROOP, 16'h0000);
		m_lo = 20;
		wr(OFS_LOW_LIMIT, 16'h0014);
		tgt <= 16'h000A;
		foreach (acts[i])
		begin
			m_act = acts[i];
			wr(OFS_BELOW_ACTION, 16'(acts[i]));
			if (acts[i] != 1)
				wf(fx(10));
		end
		for (n = 0; n < 3000 && oen !== 1'b0; n++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		chk({31'h0, oen}, 32'h0);
		m_lo = 0;
		wr(OFS_LOW_LIMIT, 16'h0000);
		wr(OFS_CONTROL, 16'h0000);
		tgt <= 16'h001E;
		wr(OFS_CONTROL, 16'h0001);
		wf(30);
		wr(OFS_REV_INHIBIT, 16'h0001);
		wr(OFS_CONTROL, 16'h0003);
		repeat (4) @(posedge clk);
		chk({30'h0, orev, irq}, 32'h0);
		wr(OFS_CONTROL, 16'h0001);
		wr(OFS_IRQ_MASK, 16'h0004);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 16'h0004);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_REV_INHIBIT, 16'h0000);
		wr(OFS_DEAD_ZONE, 16'h0002);
		wr(OFS_CONTROL, 16'h0003);
		for (n = 0; n < 3000 && orev !== 1'b1; n++)
			@(posedge clk);
		chk({31'h0, orev}, 32'h1);
		wf(30);
		wr(OFS_START_MODE, 16'h0001);
		wr(OFS_STOP_MODE, 16'h0001);
		wr(OFS_JOG_PRIO, 16'h0001);
		wr(OFS_JOG_FREQ, 16'h0019);
		chk({30'h0, smode, tmode}, 32'h3);
		jog <= 1'b1;
		wf(25);
		chk({30'h0, smode, tmode}, 32'h0);
		jog <= 1'b0;
		wr(OFS_PON_THRESH, HOURS_MAX);
		apb(1'b0, OFS_PON_TOTAL, 32'h00000000);
		wr(OFS_PON_THRESH, r[15:0] + 16'h0004);
		repeat (2) @(posedge clk);
		chk({31'h0, pon}, 32'h0);
		for (n = 0; n < 500 && pon !== 1'b1; n++)
			@(posedge clk);
		chk({31'h0, n > 20 && pon === 1'b1}, 32'h1);
		wr(OFS_RUN_ACTION, 16'h0001);
		wr(OFS_CONTROL, 16'h0000);
		wr(OFS_CONTROL, 16'h0001);
		apb(1'b0, OFS_RUN_TOTAL, 32'h00000000);
		wr(OFS_RUN_THRESH, r[15:0] + 16'h0003);
		for (n = 0; n < 500 && oen !== 1'b0; n++)
			@(posedge clk);
		chk({30'h0, runr, oen}, 32'h2);
		chk(inband, 32'h0);
		report_and_stop;
	end
endmodule // drive_aux_frequency_shaping_bench
